// [src/dsc_top.sv]
// Register file, prescalers, multiplier selection and output dividers of two synthesisers.
// Assumes the analog loops return f2 and the oscillator as one-cycle ticks on pclk,
// and that the serial receiver's controls are synchronous to pclk.
`include "dsc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dsc_top #(
	parameter int ADDR_W = 12
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                oscillator_clock_tick,
	input  wire logic                synth_a_f2_tick,
	input  wire logic                synth_b_f2_tick,
	input  wire logic                rx_enable,
	input  wire dsc_pkg::dsc_code_t  rx_div_code_a,
	input  wire logic [3:0]          rx_mult_integer,
	input  wire logic [21:0]         rx_mult_fraction,
	output logic                     synth_a_ref_tick,
	output logic                     synth_b_ref_tick,
	output logic      [3:0]          mult_integer_a,
	output logic      [21:0]         mult_fraction_a,
	output logic      [3:0]          mult_integer_b,
	output logic      [21:0]         mult_fraction_b,
	output logic                     synth_a_clock,
	output logic                     synth_b_clock
);
	// ------------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------------
	logic               input_halve_sel_a_r;
	logic               input_halve_sel_b_r;
	logic               output_div_double_a_r;
	logic               output_div_double_b_r;
	dsc_pkg::dsc_code_t output_div_code_a_r;
	dsc_pkg::dsc_code_t output_div_code_b_r;
	logic [3:0]         mult_integer_a_r;
	logic [3:0]         mult_integer_b_r;
	logic [21:0]        mult_fraction_a_r;
	logic [21:0]        mult_fraction_b_r;
	logic [31:0]        prdata_r;
	logic               pre_a_r;
	logic               pre_b_r;
	logic               ref_a_r;
	logic               ref_b_r;

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	// Word index and hit lines; unaligned or unknown addresses are errors.
	wire logic [ADDR_W-3:0] idx       = paddr[ADDR_W-1:2];
	wire logic              aligned   = (paddr[1:0] == 2'h0);
	wire logic              hit_ctl_a = aligned && (idx == (ADDR_W-2)'(`DSC_IDX_DIV_CTRL_A));
	wire logic              hit_ctl_b = aligned && (idx == (ADDR_W-2)'(`DSC_IDX_DIV_CTRL_B));
	wire logic              hit_mul_a = aligned && (idx == (ADDR_W-2)'(`DSC_IDX_MULT_A));
	wire logic              hit_mul_b = aligned && (idx == (ADDR_W-2)'(`DSC_IDX_MULT_B));
	wire logic              hit_stat  = aligned && (idx == (ADDR_W-2)'(`DSC_IDX_STATUS));
	wire logic              mapped    = hit_ctl_a || hit_ctl_b || hit_mul_a || hit_mul_b || hit_stat;
	wire logic              access    = psel && penable;
	wire logic              wr        = access && pwrite && mapped;
	wire dsc_pkg::dsc_mode_e mode     = rx_enable ? dsc_pkg::DSC_RX : dsc_pkg::DSC_USER;

	// Read word selection; bits outside each field read as zero.
	wire logic [31:0] rd_ctl_a = {27'h0, output_div_code_a_r, 1'b0,
		output_div_double_a_r, input_halve_sel_a_r};
	wire logic [31:0] rd_ctl_b = {27'h0, output_div_code_b_r, 1'b0,
		output_div_double_b_r, input_halve_sel_b_r};
	wire logic [31:0] rd_mul_a = {6'h0, mult_integer_a_r, mult_fraction_a_r};
	wire logic [31:0] rd_mul_b = {6'h0, mult_integer_b_r, mult_fraction_b_r};
	wire logic [31:0] rd_stat  = {29'h0, synth_b_clock, synth_a_clock,
		(mode == dsc_pkg::DSC_RX)};
	wire logic [31:0] rd_word  = hit_ctl_a ? rd_ctl_a :
		hit_ctl_b ? rd_ctl_b :
		hit_mul_a ? rd_mul_a :
		hit_mul_b ? rd_mul_b :
		hit_stat  ? rd_stat  : 32'h0;

	// ------------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------------
	// control field reset
	// Divider control fields reset to undivided input, code 10, no doubling.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_halve_sel_a_r   <= 1'b0;
			input_halve_sel_b_r   <= 1'b0;
			output_div_double_a_r <= 1'b0;
			output_div_double_b_r <= 1'b0;
			output_div_code_a_r   <= `DSC_RST_CODE;
			output_div_code_b_r   <= `DSC_RST_CODE;
		end else if (wr && hit_ctl_a) begin
			input_halve_sel_a_r   <= pwdata[`DSC_BIT_HALVE];
			output_div_double_a_r <= pwdata[`DSC_BIT_DOUBLE];
			output_div_code_a_r   <= pwdata[`DSC_CODE_HI:`DSC_CODE_LO];
		end else if (wr && hit_ctl_b) begin
			input_halve_sel_b_r   <= pwdata[`DSC_BIT_HALVE];
			output_div_double_b_r <= pwdata[`DSC_BIT_DOUBLE];
			output_div_code_b_r   <= pwdata[`DSC_CODE_HI:`DSC_CODE_LO];
		end
	end

	// Multiplier fields hold the integer and fractional parts of the factor.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mult_integer_a_r  <= `DSC_RST_INT;
			mult_integer_b_r  <= `DSC_RST_INT;
			mult_fraction_a_r <= `DSC_RST_FRAC;
			mult_fraction_b_r <= `DSC_RST_FRAC;
		end else if (wr && hit_mul_a) begin
			mult_integer_a_r  <= pwdata[`DSC_INT_HI:`DSC_INT_LO];
			mult_fraction_a_r <= pwdata[`DSC_FRAC_HI:`DSC_FRAC_LO];
		end else if (wr && hit_mul_b) begin
			mult_integer_b_r  <= pwdata[`DSC_INT_HI:`DSC_INT_LO];
			mult_fraction_b_r <= pwdata[`DSC_FRAC_HI:`DSC_FRAC_LO];
		end
	end

	// Read data is captured in the setup cycle, so the slave answers with no wait state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= rd_word;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	// ------------------------------------------------------------------------
	// Pre-scale dividers
	// ------------------------------------------------------------------------
	// halve oscillator ticks
	// With the select set only every second oscillator tick reaches the loop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_a_r <= 1'b0;
			pre_b_r <= 1'b0;
			ref_a_r <= 1'b0;
			ref_b_r <= 1'b0;
		end else begin
			pre_a_r <= oscillator_clock_tick ? ~pre_a_r : pre_a_r;
			pre_b_r <= oscillator_clock_tick ? ~pre_b_r : pre_b_r;
			ref_a_r <= oscillator_clock_tick && (!input_halve_sel_a_r || pre_a_r);
			ref_b_r <= oscillator_clock_tick && (!input_halve_sel_b_r || pre_b_r);
		end
	end

	assign synth_a_ref_tick = ref_a_r;
	assign synth_b_ref_tick = ref_b_r;

	// ------------------------------------------------------------------------
	// Multiplication factor to the loops
	// ------------------------------------------------------------------------
	// factor to loop
	// receiver owns A factor
	// The loop adds integer and fraction over 2^22; in receiver mode A follows the receiver.
	assign mult_integer_a  = (mode == dsc_pkg::DSC_RX) ? rx_mult_integer : mult_integer_a_r;
	assign mult_fraction_a = (mode == dsc_pkg::DSC_RX) ? rx_mult_fraction : mult_fraction_a_r;
	assign mult_integer_b  = mult_integer_b_r;
	assign mult_fraction_b = mult_fraction_b_r;

	// ------------------------------------------------------------------------
	// Output divider selection
	// ------------------------------------------------------------------------
	// code to half period
	// Half periods 1,2,4,6 f2 ticks, doubled when the doubling bit is set.
	function automatic dsc_pkg::dsc_half_t half_of(input dsc_pkg::dsc_code_t code,
		input logic dbl);
		dsc_pkg::dsc_half_t base;
		base = (code == 2'h0) ? 5'h01 : (code == 2'h1) ? 5'h02 :
			(code == 2'h2) ? 5'h04 : 5'h06;
		half_of = dbl ? {base[3:0], 1'b0} : base;
	endfunction

	// receiver mode select
	// In receiver mode A uses the receiver's code with its doubling bit as 256fs/128fs.
	wire dsc_pkg::dsc_code_t eff_code_a = (mode == dsc_pkg::DSC_RX) ? rx_div_code_a :
		output_div_code_a_r;
	wire dsc_pkg::dsc_half_t half_a = half_of(eff_code_a, output_div_double_a_r);
	wire dsc_pkg::dsc_half_t half_b = (mode == dsc_pkg::DSC_RX) ?
		half_of(`DSC_RST_CODE, 1'b0) : half_of(output_div_code_b_r, output_div_double_b_r);

	// divided synth clocks
	// Both divided clocks leave the block for pin, transmitter and converter selection.
	dsc_out_div u_div_a (
		.pclk       (pclk),
		.presetn    (presetn),
		.f2_tick    (synth_a_f2_tick),
		.half_count (half_a),
		.clk_out    (synth_a_clock)
	);

	dsc_out_div u_div_b (
		.pclk       (pclk),
		.presetn    (presetn),
		.f2_tick    (synth_b_f2_tick),
		.half_count (half_b),
		.clk_out    (synth_b_clock)
	);
endmodule
`default_nettype wire

// [src/dsc_regs.svh]
// Register indices, field positions and reset values for the dual synth dividers.
// Assumes an APB slave with 32-bit words; byte address is four times the index.
//
// How it works
// - Synth output equals input times factor
// - Factor is integer plus fraction contribution
// - Bit 0 halves oscillator clock when set
// - User mode divide by code and doubling
// - Receiver mode A doubling picks 256fs/128fs
// - Receiver sets A code, ignores B
// - Divided outputs feed pins and converters
// - Code bits 4:3 reset 10, double bit 1
// - Receiver drives A multiplier in its mode
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define DSC_IDX_DIV_CTRL_A   10'h003
`define DSC_IDX_DIV_CTRL_B   10'h007
`define DSC_IDX_MULT_A       10'h008
`define DSC_IDX_MULT_B       10'h009
`define DSC_IDX_STATUS       10'h00A

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define DSC_BIT_HALVE        0
`define DSC_BIT_DOUBLE       1
`define DSC_CODE_LO          3
`define DSC_CODE_HI          4
`define DSC_FRAC_LO          0
`define DSC_FRAC_HI          21
`define DSC_INT_LO           22
`define DSC_INT_HI           25
`define DSC_RST_CODE         2'h2
`define DSC_RST_FRAC         22'h36FD21
`define DSC_RST_INT          4'h7

`endif

// [src/dsc_pkg.sv]
// Types shared by the dual synth divider files.
// Assumes nothing of its surroundings.
package dsc_pkg;
	typedef logic [1:0] dsc_code_t;
	typedef logic [4:0] dsc_half_t;
	typedef enum logic {DSC_USER, DSC_RX} dsc_mode_e;
endpackage

// [src/dsc_out_div.sv]
// Glitch-free even output divider driven by f2 ticks.
// Assumes f2 arrives as a one-cycle tick on pclk and half_count is at least 1.
`timescale 1ns/1ps
`default_nettype none
module dsc_out_div (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                f2_tick,
	input  wire dsc_pkg::dsc_half_t  half_count,
	output logic                     clk_out
);
	dsc_pkg::dsc_half_t cnt_r;
	dsc_pkg::dsc_half_t half_r;
	logic               out_r;
	wire logic          phase_end = f2_tick && (cnt_r == half_r - 5'h01);

	// ------------------------------------------------------------------------
	// Phase counter
	// ------------------------------------------------------------------------
	// latch at period start
	// A new half count is taken only when a low phase ends, so both phases of a period match.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r  <= 5'h00;
			half_r <= 5'h04;
			out_r  <= 1'b0;
		end else if (phase_end) begin
			cnt_r <= 5'h00;
			out_r <= ~out_r;
			if (!out_r) begin
				half_r <= half_count;
			end
		end else if (f2_tick) begin
			cnt_r <= cnt_r + 5'h01;
		end
	end

	assign clk_out = out_r;
endmodule
`default_nettype wire

// [testbench/dsc_top_properties.sv]
// Port checker for the dual synth dividers.
// Assumes it is bound to every dsc_top instance.
`timescale 1ns/1ps
`default_nettype none
module dsc_top_properties #(
	parameter int ADDR_W = 12
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              oscillator_clock_tick,
	input wire logic              synth_a_f2_tick,
	input wire logic              synth_b_f2_tick,
	input wire logic              rx_enable,
	input wire logic [3:0]        rx_mult_integer,
	input wire logic              synth_a_ref_tick,
	input wire logic              synth_b_ref_tick,
	input wire logic [3:0]        mult_integer_a,
	input wire logic              synth_a_clock,
	input wire logic              synth_b_clock
);
	// All checks run on pclk and rest while reset is held.
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	mult_rx_a: assert property (rx_enable |-> mult_integer_a == rx_mult_integer)
		else $error("multiplier A ignores receiver");
	refa_cause_a: assert property (synth_a_ref_tick |-> $past(oscillator_clock_tick))
		else $error("reference tick A without oscillator tick");
	refb_cause_a: assert property (synth_b_ref_tick |-> $past(oscillator_clock_tick))
		else $error("reference tick B without oscillator tick");
	clka_cause_a: assert property ($changed(synth_a_clock) |-> $past(synth_a_f2_tick))
		else $error("clock A moved without f2 tick");
	clkb_cause_a: assert property ($changed(synth_b_clock) |-> $past(synth_b_f2_tick))
		else $error("clock B moved without f2 tick");
	// Refusals show only in the access phase.
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	err_align_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access accepted");
	ready_high_a: assert property (pready)
		else $error("wait state inserted");
endmodule

bind dsc_top dsc_top_properties #(.ADDR_W(ADDR_W)) u_dsc_top_properties (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .oscillator_clock_tick(oscillator_clock_tick),
	.synth_a_f2_tick(synth_a_f2_tick), .synth_b_f2_tick(synth_b_f2_tick),
	.rx_enable(rx_enable), .rx_mult_integer(rx_mult_integer),
	.synth_a_ref_tick(synth_a_ref_tick), .synth_b_ref_tick(synth_b_ref_tick),
	.mult_integer_a(mult_integer_a), .synth_a_clock(synth_a_clock),
	.synth_b_clock(synth_b_clock));
`default_nettype wire

// [testbench/dsc_top_tb.sv]
// Self-checking bench of dsc_top over APB.
// Assumes the design and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dsc_top_tb;
	logic               pclk, presetn, psel, penable, pwrite, osc, fa, fb, rx_en;
	logic               pready, pslverr, refa, refb, ca, cb;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, r, rc;
	dsc_pkg::dsc_code_t rx_code;
	logic [3:0]         rx_int, int_a, int_b;
	logic [21:0]        rx_frac, frac_a, frac_b;
	logic [33:0]        q[$];
	int                 n_fail, checks_done, n, m, base[4] = '{2, 4, 8, 12};

	dsc_top u_dsc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .oscillator_clock_tick(osc), .synth_a_f2_tick(fa),
		.synth_b_f2_tick(fb), .rx_enable(rx_en), .rx_div_code_a(rx_code),
		.rx_mult_integer(rx_int), .rx_mult_fraction(rx_frac), .synth_a_ref_tick(refa),
		.synth_b_ref_tick(refb), .mult_integer_a(int_a), .mult_fraction_a(frac_a),
		.mult_integer_b(int_b), .mult_fraction_b(frac_b), .synth_a_clock(ca),
		.synth_b_clock(cb));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One APB transfer; the expected outcome is queued before it starts.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [33:0] e);
		q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic e);
		apb(1'b0, a, 32'h0, {1'b1, e, x});
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d, {1'b0, e, 32'h0});
	endtask

	// Measures one divided period after two settling periods.
	task automatic period(input logic b, output int p);
		logic o;
		logic c;
		int k;
		o = 1'b1;
		k = 0;
		p = 0;
		while (k < 4) begin
			@(negedge pclk);
			c = b ? cb : ca;
			p++;
			if (c && !o) begin
				k++;
				if (k < 4) p = 0;
			end
			o = c;
		end
		@(posedge pclk);
	endtask

	// Takes the oldest note at each completed transfer and compares.
	always @(posedge pclk) begin : mon
		logic [33:0] e;
		if (psel && penable && pready === 1'b1) begin
			e = q.pop_front();
			check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
			if (e[33]) check("prdata", prdata, e[31:0]);
		end
	end

	// Cuts a hang short.
	initial begin
		#400us;
		n_fail++;
		give_verdict();
	end

	initial begin
		void'($urandom(4415));
		{psel, penable, pwrite, osc, fa, fb, rx_en} = '0;
		{paddr, pwdata, rx_code, rx_int, rx_frac} = '0;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h00C, 32'h00000010, 1'b0);
		rd(12'h01C, 32'h00000010, 1'b0);
		rd(12'h024, 32'h01F6FD21, 1'b0);
		rd(12'h020, 32'h01F6FD21, 1'b0);
		rd(12'h028, 32'h00000000, 1'b0);
		{osc, fa, fb} <= 3'h7;
		period(1'b0, n);
		check("reset div", 32'(n), 32'h8);
		for (int i = 0; i < 4; i++) begin
			rc = $urandom() & 32'h1B;
			wr(12'h00C, rc, 1'b0);
			rd(12'h00C, rc, 1'b0);
			// integer within range
			// Software keeps the integer part between 5 and 13.
			r = {6'h00, 4'(5 + $urandom_range(8)), 22'($urandom())};
			wr(12'h020, r, 1'b0);
			rd(12'h020, r, 1'b0);
			check("mult int a", {28'h0, int_a}, {28'h0, r[25:22]});
			check("mult frac a", {10'h0, frac_a}, {10'h0, r[21:0]});
		end
		// factor 8.192 loaded
		// Whole part 8 and truncated fraction 0xC49BA go to synth B.
		wr(12'h024, 32'h020C49BA, 1'b0);
		check("mult int b", {28'h0, int_b}, 32'h00000008);
		check("mult frac b", {10'h0, frac_b}, 32'h000C49BA);
		wr(12'h030, 32'hFFFFFFFF, 1'b1);
		rd(12'h00D, 32'h0, 1'b1);
		rd(12'h00C, rc, 1'b0);
		rd(12'h020, r, 1'b0);
		$display("test registers done");
		for (int c = 0; c < 8; c++) begin
			wr(12'h00C, {27'h0, c[1:0], 1'b0, c[2], 1'b0}, 1'b0);
			wr(12'h01C, {27'h0, ~c[1:0], 1'b0, ~c[2], 1'b0}, 1'b0);
			period(1'b0, n);
			check("div a", 32'(n), 32'(base[c[1:0]] * (c[2] ? 2 : 1)));
			period(1'b1, n);
			check("div b", 32'(n), 32'(base[~c[1:0]] * (c[2] ? 1 : 2)));
		end
		$display("test dividers done");
		for (int h = 0; h < 2; h++) begin
			wr(12'h00C, {31'h0, h[0]}, 1'b0);
			wr(12'h01C, {31'h0, ~h[0]}, 1'b0);
			n = 0;
			m = 0;
			repeat (40) begin
				@(negedge pclk);
				n += (refa === 1'b1) ? 1 : 0;
				m += (refb === 1'b1) ? 1 : 0;
			end
			@(posedge pclk);
			check("ref a", 32'(n), h ? 32'd20 : 32'd40);
			check("ref b", 32'(m), h ? 32'd40 : 32'd20);
		end
		$display("test prescale done");
		rx_code <= 2'($urandom());
		rx_int <= 4'($urandom());
		rx_frac <= 22'($urandom());
		rx_en <= 1'b1;
		// prescales kept equal
		// Both pre-scale selects are written as 0 while the receiver runs.
		wr(12'h00C, 32'h2, 1'b0);
		wr(12'h01C, 32'h1A, 1'b0);
		check("rx mult", {28'h0, int_a}, {28'h0, rx_int});
		check("rx frac", {10'h0, frac_a}, {10'h0, rx_frac});
		check("rx mult b", {28'h0, int_b}, 32'h00000008);
		// B clock feeds nothing
		// The bench measures the A clock, then the B clock, here and routes neither anywhere.
		period(1'b0, n);
		check("rx div a", 32'(n), 32'(base[rx_code] * 2));
		period(1'b1, n);
		check("rx div b", 32'(n), 32'h8);
		$display("test receiver done");
		give_verdict();
	end
endmodule
`default_nettype wire
